//--- core/trig_seq.v
// Trigger sequencer: input-trigger waits with optional step delay and broadcast
// Assumes AXI4-Lite master; trig_in is asynchronous and synchronised here
//
// How it works
// - modes 11/10 level detect; 11 skips delay
// - modes 01/00 edge detect; 01 skips delay
// - mode used only by wait commands
// - upper broadcast bits pulse converter/capture triggers
// - compare clock bits pulse compare clocks
// - software trigger acts only in step option
`include "trig_seq_defines.vh"
module trig_seq #(
  parameter DELAY_W = 8
) (
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire [3:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [3:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        trig_in,
  output reg  [15:0] bcast_out,
  output reg         sw_trig_out,
  output reg         step_done
);

////////////////////////////////////////////////////////////////////////////////
reg  [15:0] broadcast_enable_reg;
reg  [4:0]  ctrl;
reg  [3:0]  cmd_op;
reg  [3:0]  cmd_arg;
reg         cmd_pend;
reg         busy;
reg  [3:0]  cur_op;
reg         pol_high;
reg  [DELAY_W-1:0] delay_cnt;
reg         delaying;
reg         trig_s1;
reg         trig_s2;
reg         trig_prev;
reg  [3:0]  aw_addr;
reg         aw_have;
reg  [31:0] w_data;
reg         w_have;
wire [1:0]  itm = ctrl[1:0];
wire        trig_at = pol_high ? trig_s2 : ~trig_s2;
wire        trig_edge = pol_high ? (trig_s2 & ~trig_prev) : (~trig_s2 & trig_prev);
wire        hit = itm[1] ? trig_at : trig_edge;
wire        skip_delay = itm[0];
wire        wr_go = aw_have & w_have & ~s_axi_bvalid;

function ok_addr;
  input [3:0] a;
  begin
    ok_addr = (a == `CTRL_OFFSET) || (a == `BCAST_OFFSET) ||
              (a == `CMD_OFFSET) || (a == `STATUS_OFFSET);
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Input synchroniser
always @(posedge core_clk or negedge reset_n) begin
  if (!reset_n) begin
    trig_s1   <= 1'b0;
    trig_s2   <= 1'b0;
    trig_prev <= 1'b0;
  end else begin
    trig_s1   <= trig_in;
    trig_s2   <= trig_s1;
    trig_prev <= trig_s2;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Write channel; address and data accepted in either order
always @(posedge core_clk or negedge reset_n) begin
  if (!reset_n) begin
    s_axi_awready        <= 1'b1;
    s_axi_wready         <= 1'b1;
    aw_have              <= 1'b0;
    w_have               <= 1'b0;
    aw_addr              <= 4'h0;
    w_data               <= 32'h00000000;
    s_axi_bvalid         <= 1'b0;
    s_axi_bresp          <= 2'h0;
    broadcast_enable_reg <= `BCAST_RESET;
    ctrl                 <= 5'h00;
    cmd_op               <= 4'h0;
    cmd_arg              <= 4'h0;
    cmd_pend             <= 1'b0;
  end else begin
    if (s_axi_awvalid && s_axi_awready) begin
      aw_addr       <= s_axi_awaddr;
      aw_have       <= 1'b1;
      s_axi_awready <= 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_data       <= s_axi_wdata;
      w_have       <= 1'b1;
      s_axi_wready <= 1'b0;
    end
    // Pending command is kept until the run bit lets the engine take it
    if (cmd_pend && !busy && ctrl[`RUN_BIT])
      cmd_pend <= 1'b0;
    if (wr_go) begin
      aw_have      <= 1'b0;
      w_have       <= 1'b0;
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= ok_addr(aw_addr) ? 2'h0 : 2'h2;
      case (aw_addr)
        `CTRL_OFFSET: begin
          if (s_axi_wstrb[0])
            ctrl <= w_data[4:0];
        end
        `BCAST_OFFSET: begin
          if (s_axi_wstrb[0])
            broadcast_enable_reg[7:0] <= w_data[7:0];
          if (s_axi_wstrb[1])
            broadcast_enable_reg[15:8] <= w_data[15:8];
        end
        `CMD_OFFSET: begin
          // Commands written while one runs are dropped
          if (s_axi_wstrb[0] && !cmd_pend && !busy) begin
            cmd_op   <= w_data[7:4];
            cmd_arg  <= w_data[3:0];
            cmd_pend <= 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid  <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// Read channel
always @(posedge core_clk or negedge reset_n) begin
  if (!reset_n) begin
    s_axi_arready <= 1'b1;
    s_axi_rvalid  <= 1'b0;
    s_axi_rdata   <= 32'h00000000;
    s_axi_rresp   <= 2'h0;
  end else if (s_axi_arvalid && s_axi_arready) begin
    s_axi_arready <= 1'b0;
    s_axi_rvalid  <= 1'b1;
    s_axi_rresp   <= ok_addr(s_axi_araddr) ? 2'h0 : 2'h2;
    // Unused upper bits read as zero
    case (s_axi_araddr)
      `CTRL_OFFSET: begin
        s_axi_rdata <= {27'h0000000, ctrl};
      end
      `BCAST_OFFSET: begin
        s_axi_rdata <= {16'h0000, broadcast_enable_reg};
      end
      `CMD_OFFSET: begin
        s_axi_rdata <= {24'h000000, cmd_op, cmd_arg};
      end
      `STATUS_OFFSET: begin
        // Synced level only; raw pin may be metastable
        s_axi_rdata <= {28'h0000000, delaying, trig_s2, cmd_pend, busy};
      end
      default: begin
        s_axi_rdata <= 32'h00000000;
      end
    endcase
  end else if (s_axi_rvalid && s_axi_rready) begin
    s_axi_rvalid  <= 1'b0;
    s_axi_arready <= 1'b1;
  end
end

////////////////////////////////////////////////////////////////////////////////
// Command engine; step delay is a fixed count, single-step bit is
// stored only for debug tools and changes nothing here
always @(posedge core_clk or negedge reset_n) begin
  if (!reset_n) begin
    busy        <= 1'b0;
    cur_op      <= 4'h0;
    pol_high    <= 1'b0;
    delaying    <= 1'b0;
    delay_cnt   <= {DELAY_W{1'b0}};
    bcast_out   <= 16'h0000;
    sw_trig_out <= 1'b0;
    step_done   <= 1'b0;
  end else begin
    bcast_out   <= 16'h0000;
    sw_trig_out <= 1'b0;
    step_done   <= 1'b0;
    if (!busy) begin
      if (cmd_pend && ctrl[`RUN_BIT]) begin
        case (cmd_op)
          `CMD_WAIT_HIGH, `CMD_WAIT_LOW: begin
            busy     <= 1'b1;
            cur_op   <= cmd_op;
            pol_high <= (cmd_op == `CMD_WAIT_HIGH);
            delaying <= 1'b0;
          end
          `CMD_BROADCAST: begin
            bcast_out <= broadcast_enable_reg;
            step_done <= 1'b1;
          end
          `CMD_CTRL_STEP: begin
            // Trigger fires only for the software-trigger option
            sw_trig_out <= ctrl[`SWTRIG_BIT] && (cmd_arg == `STEP_OPT_SWTRIG);
            step_done   <= 1'b1;
          end
          `CMD_STEP_DELAY: begin
            busy      <= 1'b1;
            cur_op    <= cmd_op;
            delaying  <= 1'b1;
            delay_cnt <= `STEP_DELAY_RESET;
          end
          default: step_done <= 1'b1;
        endcase
      end
    end else if (delaying) begin
      if (delay_cnt == {DELAY_W{1'b0}}) begin
        busy      <= 1'b0;
        delaying  <= 1'b0;
        step_done <= 1'b1;
      end else
        delay_cnt <= delay_cnt - 1'b1;
    end else if (hit) begin
      if (skip_delay) begin
        busy      <= 1'b0;
        step_done <= 1'b1;
      end else begin
        delaying  <= 1'b1;
        delay_cnt <= `STEP_DELAY_RESET;
      end
    end
  end
end

endmodule // trig_seq

//--- core/trig_seq_defines.vh
// Constants for the trigger sequencer broadcast and input-trigger block
// Assumes a 32-bit AXI4-Lite register bus
`ifndef TRIG_SEQ_DEFINES_VH
`define TRIG_SEQ_DEFINES_VH
`define CTRL_OFFSET      4'h0
`define BCAST_OFFSET     4'h4
`define CMD_OFFSET       4'h8
`define STATUS_OFFSET    4'hC
`define BCAST_RESET      16'h0000
`define ITM_RESET        2'h0
`define ITM_LSB          0
`define SWTRIG_BIT       2
`define SSTEP_BIT        3
`define RUN_BIT          4
`define CMD_WAIT_HIGH    4'h1
`define CMD_WAIT_LOW     4'h2
`define CMD_BROADCAST    4'h3
`define CMD_CTRL_STEP    4'h4
`define CMD_STEP_DELAY   4'h5
`define STEP_OPT_SWTRIG  4'hF
`define STEP_DELAY_RESET 8'h04
`endif

//--- dv/trig_seq_asserts.sv
// Checker of the trigger output pulses
// Bound into trig_seq; sees only its ports
module trig_seq_asserts (
  input wire        core_clk,
  input wire        reset_n,
  input wire [15:0] bcast_out,
  input wire        sw_trig_out,
  input wire        step_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_EXIT: assert property (step_done |=> !step_done)
    else $error("step end held too long");
  AST_SEP: assert property (bcast_out != 16'h0000 |-> !sw_trig_out)
    else $error("software trigger during broadcast");
  AST_UP: assert property ((|bcast_out[15:8]) |-> step_done)
    else $error("upper trigger outside broadcast end");
  AST_CLK: assert property ((|bcast_out[7:4]) |-> step_done)
    else $error("compare clock outside broadcast end");
  AST_SW: assert property (sw_trig_out |=> !sw_trig_out)
    else $error("software trigger held too long");
  AST_ONE: assert property (bcast_out != 16'h0000 |=> bcast_out == 16'h0000)
    else $error("broadcast held too long");
endmodule // trig_seq_asserts
bind trig_seq trig_seq_asserts u_chk (.core_clk(core_clk), .reset_n(reset_n),
  .bcast_out(bcast_out), .sw_trig_out(sw_trig_out), .step_done(step_done));

//--- dv/periph_side_model.sv
// Converter, capture and compare units as seen by the sequencer
// Same clock and reset as the sequencer; counts pulses it receives
module periph_side_model (
  input  wire         core_clk,
  input  wire         reset_n,
  input  wire  [15:0] bcast_out,
  input  wire         sw_trig_out,
  input  wire         lvl,
  output logic        trig_in,
  output logic [15:0] last_bc,
  output logic [31:0] n_bc,
  output logic [31:0] n_sw
);
  timeunit 1ns;
  timeprecision 1ps;
  assign trig_in = lvl;
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {last_bc, n_bc, n_sw} <= 80'h0;
    end else begin
      if (bcast_out != 16'h0000) begin
        n_bc <= n_bc + 32'h1;
        last_bc <= bcast_out;
      end
      if (sw_trig_out)
        n_sw <= n_sw + 32'h1;
    end
  end
endmodule // periph_side_model

//--- dv/trig_seq_tb.sv
// Bench for the trigger sequencer
// AXI4-Lite master by non-blocking assignment; peripherals modelled apart
`include "trig_seq_defines.vh"
module trig_seq_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'h0, reset_n = 1'h0, lvl = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0, rd_v, t [4];
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  wire         awready, wready, bvalid, arready, rvalid, trig_in, sw_trig_out, step_done;
  wire  [1:0]  rresp, bresp;
  logic [1:0]  rd_r, wr_r;
  wire  [31:0] rdata, n_bc, n_sw;
  wire  [15:0] bcast_out, last_bc;
  int          error_cnt = 0;
  int          num_checks = 0;
  always #12.5 core_clk = ~core_clk;
  trig_seq dut (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .trig_in(trig_in), .bcast_out(bcast_out),
    .sw_trig_out(sw_trig_out), .step_done(step_done));
  periph_side_model far (.core_clk(core_clk), .reset_n(reset_n), .bcast_out(bcast_out),
    .sw_trig_out(sw_trig_out), .lvl(lvl), .trig_in(trig_in), .last_bc(last_bc),
    .n_bc(n_bc), .n_sw(n_sw));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        wr_r = bresp;
        bready <= 1'h0;
      end
    end while (awvalid || wvalid || bready);
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge core_clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rd_v = rdata;
        rd_r = rresp;
        rready <= 1'h0;
      end
    end while (arvalid || rready);
    @(posedge core_clk);
  endtask
  // Commands pass through pending, so leave room before the next
  task automatic cmd(input logic [3:0] op, input logic [3:0] opt);
    wr(`CMD_OFFSET, {24'h0, op, opt});
    repeat (8) @(posedge core_clk);
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'h1;
    @(posedge core_clk);
    rd(`BCAST_OFFSET);
    chk(rd_v, {16'h0, `BCAST_RESET});
    rd(4'h2);
    chk({30'h0, rd_r}, 32'h2);
    wr(4'h2, 32'h0);
    chk({30'h0, wr_r}, 32'h2);
    wr(`BCAST_OFFSET, 32'hA5B3);
    rd(`BCAST_OFFSET);
    chk(rd_v, 32'hA5B3);
    cmd(`CMD_BROADCAST, 4'h0);
    chk(n_bc, 32'h0);
    wr(`CTRL_OFFSET, 32'h10); // Single-step bit never set
    repeat (8) @(posedge core_clk);
    chk(n_bc, 32'h1);
    chk({16'h0, last_bc}, 32'hA5B3);
    wr(`BCAST_OFFSET, 32'h0);
    cmd(`CMD_BROADCAST, 4'h0);
    chk(n_bc, 32'h1);
    wr(`CTRL_OFFSET, 32'h14);
    cmd(`CMD_CTRL_STEP, `STEP_OPT_SWTRIG);
    chk(n_sw, 32'h1);
    cmd(`CMD_CTRL_STEP, 4'h0);
    chk(n_sw, 32'h1);
    for (int m = 3; m >= 0; m--) begin
      wr(`CTRL_OFFSET, 32'h10 + m);
      cmd(`CMD_WAIT_HIGH, 4'h0);
      lvl <= 1'h1;
      t[m] = 32'h0;
      while (!step_done && t[m] < 32'h28) begin
        @(posedge core_clk);
        t[m] = t[m] + 32'h1;
      end
      lvl <= 1'h0;
      repeat (8) @(posedge core_clk);
    end
    chk(t[2], t[3] + `STEP_DELAY_RESET + 32'h1);
    chk(t[0], t[1] + `STEP_DELAY_RESET + 32'h1);
    give_verdict();
  end
  initial begin
    #(4000 * 25);
    error_cnt++;
    give_verdict();
  end
endmodule // trig_seq_tb
